/* File: hdl/fic_pkg.sv */
// Shared constants and types for the four-level interrupt controller.
// Assumes a core sequencer that strobes the sampling phase once per
// machine cycle and flags the final cycle of each instruction.
package fic_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned FIC_NUM_SRC    = 6;
  localparam int unsigned FIC_NUM_LEVELS = 4;
  localparam int unsigned FIC_VEC_W      = 8;

  // Source index doubles as polling order, lowest index polled first
  localparam logic [2:0] FIC_SRC_EXT0   = 3'h0;
  localparam logic [2:0] FIC_SRC_TMR0   = 3'h1;
  localparam logic [2:0] FIC_SRC_EXT1   = 3'h2;
  localparam logic [2:0] FIC_SRC_TMR1   = 3'h3;
  localparam logic [2:0] FIC_SRC_SERIAL = 3'h4;
  localparam logic [2:0] FIC_SRC_TMR2   = 3'h5;

  //////////////////////////////////////////////////////////////////////////
  // Fixed vectors per source
  localparam logic [7:0] FIC_VEC_EXT0   = 8'h03;
  localparam logic [7:0] FIC_VEC_TMR0   = 8'h0B;
  localparam logic [7:0] FIC_VEC_EXT1   = 8'h13;
  localparam logic [7:0] FIC_VEC_TMR1   = 8'h1B;
  localparam logic [7:0] FIC_VEC_SERIAL = 8'h23;
  localparam logic [7:0] FIC_VEC_TMR2   = 8'h2B;

  //////////////////////////////////////////////////////////////////////////
  // Timing and reset values
  localparam int unsigned FIC_CALL_CYCLES = 2;  // Machine cycles per call
  localparam logic [3:0]  FIC_IN_PROG_RST = 4'h0;
  localparam logic        FIC_FLAG_RST    = 1'b0;
  localparam logic        FIC_PIN_RST     = 1'b1;  // Idle pin is high
  localparam logic [7:0]  FIC_VEC_RST     = 8'h00;

  // Injected-call sequencer states
  typedef enum logic [1:0] {
    FIC_IDLE,
    FIC_CALL_FIRST,
    FIC_CALL_SECOND
  } fic_call_state_e;

  // Vector lookup, used by the top and available to the bench
  function automatic logic [7:0] fic_vector(input logic [2:0] src);
    logic [7:0] vec;
    vec = FIC_VEC_EXT0;
    case (src)
      FIC_SRC_EXT0:   vec = FIC_VEC_EXT0;
      FIC_SRC_TMR0:   vec = FIC_VEC_TMR0;
      FIC_SRC_EXT1:   vec = FIC_VEC_EXT1;
      FIC_SRC_TMR1:   vec = FIC_VEC_TMR1;
      FIC_SRC_SERIAL: vec = FIC_VEC_SERIAL;
      FIC_SRC_TMR2:   vec = FIC_VEC_TMR2;
      default:        vec = FIC_VEC_EXT0;
    endcase
    return vec;
  endfunction

endpackage

/* File: hdl/fic_resolver.sv */
// Combinational arbiter: picks the highest level, then polling order.
// Assumes pending bits are already gated by the enables.
module fic_resolver
  import fic_pkg::*;
#(
  parameter int unsigned NUM_SRC = FIC_NUM_SRC
) (
  input  wire logic [NUM_SRC-1:0] i_pending,
  input  wire logic [NUM_SRC-1:0] i_priority_low_bits,
  input  wire logic [NUM_SRC-1:0] i_priority_high_bits,
  output logic                    o_found,
  output logic [2:0]              o_src,
  output logic [1:0]              o_level
);

  //////////////////////////////////////////////////////////////////////////
  // Scan from last polled source down, so earlier sources win ties
  always_comb begin
    logic [1:0] lvl;
    lvl     = 2'h0;
    o_found = 1'b0;
    o_src   = 3'h0;
    o_level = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      lvl = {i_priority_high_bits[i], i_priority_low_bits[i]};
      if (i_pending[i] && (!o_found || lvl >= o_level)) begin
        o_found = 1'b1;
        o_src   = 3'(i);
        o_level = lvl;
      end
    end
  end

endmodule

/* File: hdl/fic_controller.sv */
// Six-source, four-level nested interrupt controller for an 8-bit core.
// Assumes the core sequencer strobes the sampling phase once per machine
// cycle, flags the final cycle of each instruction, and executes the
// injected call when o_call_start pulses.
//
// Overview of operation
// - Higher-level request seen during a call chains straight into another call.
// - Serial receive and transmit flags are never cleared by this block.
// - Vectoring clears an external flag only in edge mode.
// - Injected call pushes the program counter only, then loads the vector.
// - Vectors 03H, 0BH, 13H, 1BH, 23H, 2BH per source.
// - Return-from-interrupt clears current level, then pops two bytes to PC.
// - Plain return leaves the in-progress level set.
// - Trigger type 0: low sample on the pin raises the request.
// - Trigger type 1: high sample then low sample sets the flag.
// - Pins inverted and latched each sampling phase, snapshot at the next one, polled the cycle after.
// - Call lasts two machine cycles; at least three cycles to service.
// - Wait for instruction end; after return or enable access, one more.
// - Level is high-priority bit over priority bit, 00 lowest, 11 highest.
// - Equal or higher level in service blocks; lower level is preempted.
// - Equal levels resolved by fixed order, external 0 first, timer 2 last.
// - Timer 0 and timer 1 overflow flags cleared on vectoring.
// - No call unless final instruction cycle and no equal-or-higher level.
// - Global enable masks all sources beside per-source enables.
module fic_controller
  import fic_pkg::*;
#(
  parameter int unsigned NUM_SRC = FIC_NUM_SRC
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  // Core sequencer timing
  input  wire logic               i_sample_phase_strobe,
  input  wire logic               i_instr_last_cycle,
  input  wire logic               i_blocking_instr,
  input  wire logic               i_return_from_irq_instr,
  // External pins, active low, and their trigger types
  input  wire logic               i_ext0_request_pin_n,
  input  wire logic               i_ext1_request_pin_n,
  input  wire logic               i_ext0_trigger_type,
  input  wire logic               i_ext1_trigger_type,
  // Peripheral events and flags
  input  wire logic               i_timer0_overflow_set,
  input  wire logic               i_timer1_overflow_set,
  input  wire logic               i_timer2_overflow_flag,
  input  wire logic               i_timer2_external_flag,
  input  wire logic               i_serial_receive_flag,
  input  wire logic               i_serial_transmit_flag,
  // Software writes to the four locally held flags
  input  wire logic [3:0]         i_flag_wr_en,
  input  wire logic [3:0]         i_flag_wr_data,
  // Enable and priority configuration
  input  wire logic               i_global_irq_enable,
  input  wire logic [NUM_SRC-1:0] i_source_enable,
  input  wire logic [NUM_SRC-1:0] i_priority_low_bits,
  input  wire logic [NUM_SRC-1:0] i_priority_high_bits,
  // Call injection toward the core
  output logic                    o_call_start,
  output logic                    o_call_busy,
  output logic [FIC_VEC_W-1:0]    o_call_vector,
  output logic                    o_pop_pc,
  // Visible state
  output logic                    o_ext0_request_flag,
  output logic                    o_ext1_request_flag,
  output logic                    o_timer0_overflow_flag,
  output logic                    o_timer1_overflow_flag,
  output logic [3:0]              o_level_in_progress
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  fic_call_state_e      state_reg;
  fic_call_state_e      state_next;
  logic                 busy_reg;
  logic                 busy_next;
  logic                 call_start_reg;
  logic                 call_start_next;
  logic [7:0]           vector_reg;
  logic [7:0]           vector_next;
  logic                 pop_pc_reg;
  logic                 pop_pc_next;
  logic [3:0]           in_prog_reg;
  logic [3:0]           in_prog_next;
  logic [1:0]           pin_prev_reg;
  logic [1:0]           pin_prev_next;
  logic [1:0]           ext_flag_reg;
  logic [1:0]           ext_flag_next;
  logic [1:0]           tmr_flag_reg;
  logic [1:0]           tmr_flag_next;
  logic [NUM_SRC-1:0]   sampled_reg;
  logic [NUM_SRC-1:0]   sampled_next;

  logic [NUM_SRC-1:0]   live_req;
  logic [NUM_SRC-1:0]   pending;
  logic                 found;
  logic [2:0]           win_src;
  logic [1:0]           win_level;
  logic                 poll_ok;
  logic                 level_ok;
  logic                 grant;
  logic [1:0]           pin_n;
  logic [1:0]           trig;
  logic [1:0]           tmr_set;

  assign pin_n   = {i_ext1_request_pin_n, i_ext0_request_pin_n};
  assign trig    = {i_ext1_trigger_type, i_ext0_trigger_type};
  assign tmr_set = {i_timer1_overflow_set, i_timer0_overflow_set};

  // True when any level at or above lvl is already in service
  function automatic logic level_busy(input logic [3:0] prog,
                                      input logic [1:0] lvl);
    logic busy;
    busy = 1'b0;
    for (int k = 0; k < FIC_NUM_LEVELS; k++) begin
      if (prog[k] && (2'(k) >= lvl)) begin
        busy = 1'b1;
      end
    end
    return busy;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Live request lines in polling order; serial and timer 2 flags are
  // owned by their peripherals and only read here
  always_comb begin
    live_req                 = '0;
    live_req[FIC_SRC_EXT0]   = ext_flag_reg[0];
    live_req[FIC_SRC_TMR0]   = tmr_flag_reg[0];
    live_req[FIC_SRC_EXT1]   = ext_flag_reg[1];
    live_req[FIC_SRC_TMR1]   = tmr_flag_reg[1];
    live_req[FIC_SRC_SERIAL] = i_serial_receive_flag |
                               i_serial_transmit_flag;
    live_req[FIC_SRC_TMR2]   = i_timer2_overflow_flag |
                               i_timer2_external_flag;
  end

  //////////////////////////////////////////////////////////////////////////
  // Snapshot at each sampling phase, polled during the next machine cycle
  always_comb begin
    sampled_next = sampled_reg;
    if (i_sample_phase_strobe) begin
      sampled_next = live_req;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sampled_reg <= '0;
    end else begin
      sampled_reg <= sampled_next;
    end
  end

  // Masking by per-source and global enables
  assign pending = sampled_reg & i_source_enable &
                   {NUM_SRC{i_global_irq_enable}};

  //////////////////////////////////////////////////////////////////////////
  // Arbitration
  fic_resolver #(
    .NUM_SRC              (NUM_SRC)
  ) u_resolver (
    .i_pending            (pending),
    .i_priority_low_bits  (i_priority_low_bits),
    .i_priority_high_bits (i_priority_high_bits),
    .o_found              (found),
    .o_src                (win_src),
    .o_level              (win_level)
  );

  // The final call cycle counts as an instruction end, so a higher level
  // that arrives meanwhile chains in before the lower routine runs
  assign poll_ok  = ((state_reg == FIC_IDLE) && i_instr_last_cycle &&
                     !i_blocking_instr) ||
                    (state_reg == FIC_CALL_SECOND);
  assign level_ok = !level_busy(in_prog_reg, win_level);
  assign grant    = i_sample_phase_strobe && poll_ok &&
                    found && level_ok;

  //////////////////////////////////////////////////////////////////////////
  // External request flags: level mode follows the pin, edge mode latches
  always_comb begin
    pin_prev_next = pin_prev_reg;
    ext_flag_next = ext_flag_reg;
    for (int e = 0; e < 2; e++) begin
      // Software write first, hardware events below override it
      if (i_flag_wr_en[e]) begin
        ext_flag_next[e] = i_flag_wr_data[e];
      end
      // Vector clear only for edge mode
      if (grant && trig[e] && (win_src == 3'(2 * e))) begin
        ext_flag_next[e] = 1'b0;
      end
      if (i_sample_phase_strobe) begin
        pin_prev_next[e] = pin_n[e];
        if (!trig[e]) begin
          ext_flag_next[e] = !pin_n[e];
        end else if (pin_prev_reg[e] && !pin_n[e]) begin
          ext_flag_next[e] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_prev_reg <= {2{FIC_PIN_RST}};
      ext_flag_reg <= {2{FIC_FLAG_RST}};
    end else begin
      pin_prev_reg <= pin_prev_next;
      ext_flag_reg <= ext_flag_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer 0/1 overflow flags; an overflow in the clearing cycle wins
  always_comb begin
    tmr_flag_next = tmr_flag_reg;
    for (int t = 0; t < 2; t++) begin
      if (i_flag_wr_en[2 + t]) begin
        tmr_flag_next[t] = i_flag_wr_data[2 + t];
      end
      if (grant && (win_src == 3'(2 * t + 1))) begin
        tmr_flag_next[t] = 1'b0;
      end
      if (tmr_set[t]) begin
        tmr_flag_next[t] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tmr_flag_reg <= {2{FIC_FLAG_RST}};
    end else begin
      tmr_flag_reg <= tmr_flag_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Call sequencer: two machine cycles per injected call
  always_comb begin
    state_next      = state_reg;
    call_start_next = 1'b0;
    vector_next     = vector_reg;
    case (state_reg)
      FIC_IDLE: begin
        if (grant) begin
          state_next = FIC_CALL_FIRST;
        end
      end
      FIC_CALL_FIRST: begin
        if (i_sample_phase_strobe) begin
          state_next = FIC_CALL_SECOND;
        end
      end
      FIC_CALL_SECOND: begin
        if (grant) begin
          state_next = FIC_CALL_FIRST;
        end else if (i_sample_phase_strobe) begin
          state_next = FIC_IDLE;
        end
      end
      default: begin
        state_next = FIC_IDLE;
      end
    endcase
    // Core pushes PC only, status word is left alone
    if (grant) begin
      call_start_next = 1'b1;
      vector_next     = fic_vector(win_src);
    end
    // Busy registered beside the state so the port needs no decode
    busy_next = (state_next != FIC_IDLE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg      <= FIC_IDLE;
      busy_reg       <= 1'b0;
      call_start_reg <= 1'b0;
      vector_reg     <= FIC_VEC_RST;
    end else begin
      state_reg      <= state_next;
      busy_reg       <= busy_next;
      call_start_reg <= call_start_next;
      vector_reg     <= vector_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // In-progress levels; only the dedicated return clears one, so a plain
  // return leaves the level blocking
  always_comb begin
    logic done;
    done         = 1'b0;
    in_prog_next = in_prog_reg;
    pop_pc_next  = 1'b0;
    if (i_return_from_irq_instr) begin
      pop_pc_next = 1'b1;
      for (int k = FIC_NUM_LEVELS - 1; k >= 0; k--) begin
        if (in_prog_reg[k] && !done) begin
          in_prog_next[k] = 1'b0;
          done            = 1'b1;
        end
      end
    end
    // Set after clear so a new call is never lost
    if (grant) begin
      in_prog_next[win_level] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      in_prog_reg <= FIC_IN_PROG_RST;
      pop_pc_reg  <= 1'b0;
    end else begin
      in_prog_reg <= in_prog_next;
      pop_pc_reg  <= pop_pc_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign o_call_start           = call_start_reg;
  assign o_call_busy            = busy_reg;
  assign o_call_vector          = vector_reg;
  assign o_pop_pc               = pop_pc_reg;
  assign o_ext0_request_flag    = ext_flag_reg[0];
  assign o_ext1_request_flag    = ext_flag_reg[1];
  assign o_timer0_overflow_flag = tmr_flag_reg[0];
  assign o_timer1_overflow_flag = tmr_flag_reg[1];
  assign o_level_in_progress    = in_prog_reg;

endmodule

/* File: bench/fic_checker.sv */
// Concurrent checks on the interrupt controller top ports.
// Assumes enables and priorities stay steady around each call.
module fic_checker
  import fic_pkg::*;
#(
  parameter int unsigned NUM_SRC = FIC_NUM_SRC
) (
  input wire logic               i_sys_clk,
  input wire logic               i_rst,
  input wire logic               i_sample_phase_strobe,
  input wire logic               i_instr_last_cycle,
  input wire logic               i_blocking_instr,
  input wire logic               i_return_from_irq_instr,
  input wire logic               i_ext0_request_pin_n,
  input wire logic               i_ext0_trigger_type,
  input wire logic               i_timer0_overflow_set,
  input wire logic [3:0]         i_flag_wr_en,
  input wire logic               i_global_irq_enable,
  input wire logic [NUM_SRC-1:0] i_source_enable,
  input wire logic [NUM_SRC-1:0] i_priority_low_bits,
  input wire logic [NUM_SRC-1:0] i_priority_high_bits,
  input wire logic               o_call_start,
  input wire logic               o_call_busy,
  input wire logic [7:0]         o_call_vector,
  input wire logic               o_pop_pc,
  input wire logic               o_ext0_request_flag,
  input wire logic               o_timer0_overflow_flag,
  input wire logic [3:0]         o_level_in_progress
);
  logic [2:0] src;
  logic [1:0] lvl;

  // Source and level implied by the vector on the call port
  assign src = o_call_vector[5:3];
  assign lvl = {i_priority_high_bits[src], i_priority_low_bits[src]};

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////
  a_call_busy_two: assert property (
    o_call_start |-> o_call_busy ##1 (o_call_busy && !o_call_start))
    else $error("call busy too short");
  a_grant_on_strobe: assert property (
    o_call_start |-> $past(i_sample_phase_strobe))
    else $error("call without sampling strobe");
  a_vector_fixed: assert property (
    o_call_start |-> o_call_vector inside
      {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B})
    else $error("call vector not a fixed one");
  a_level_mark: assert property (
    o_call_start |-> o_level_in_progress[lvl])
    else $error("level bit not set on call");
  a_level_block: assert property (
    o_call_start |-> ($past(o_level_in_progress) >> lvl) == 4'h0)
    else $error("call while equal or higher level busy");
  a_instr_end: assert property (
    o_call_start && !$past(o_call_busy) |->
      $past(i_instr_last_cycle) && !$past(i_blocking_instr))
    else $error("call outside instruction end");
  a_global_mask: assert property (
    o_call_start |-> $past(i_global_irq_enable) && i_source_enable[src])
    else $error("call from a masked source");
  a_pop_pulse: assert property (
    i_return_from_irq_instr |=> o_pop_pc ##1 !o_pop_pc)
    else $error("pop pulse wrong");
  a_tmr0_clear: assert property (
    o_call_start && src == 3'h1 && !$past(i_timer0_overflow_set)
      |-> !o_timer0_overflow_flag)
    else $error("timer 0 flag kept on call");
  a_edge_clear: assert property (
    o_call_start && src == 3'h0 && $past(i_ext0_trigger_type) &&
      $past(i_ext0_request_pin_n) && !$past(i_flag_wr_en[0])
      |-> !o_ext0_request_flag)
    else $error("edge flag kept on call");

  // Main scenarios reached
  c_nested: cover property (o_call_start && $past(o_level_in_progress) != 0);
  c_chain:  cover property (o_call_start && $past(o_call_busy));
  c_pop:    cover property (o_pop_pc);
endmodule

bind fic_controller fic_checker #(.NUM_SRC(NUM_SRC)) u_chk (.*);

/* File: bench/fic_core_model.sv */
// Core sequencer model: machine cycle strobe and instruction end.
// Assumes a machine cycle of MC_CLKS system clocks.
module fic_core_model #(
  parameter int unsigned MC_CLKS = 4
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_instr_len,
  output logic            o_strobe,
  output logic            o_last_cycle
);
  int unsigned phase = 0;
  int unsigned mcyc  = 0;

  // Moves off the sampling edge so the block sees settled levels
  always @(negedge i_sys_clk) begin
    if (i_rst) begin
      phase = 0;
      mcyc = 0;
      o_strobe <= 1'b0;
      o_last_cycle <= 1'b0;
    end else if (phase == MC_CLKS - 1) begin
      phase = 0;
      o_strobe <= 1'b1;
      o_last_cycle <= (mcyc == int'(i_instr_len));
      mcyc = (mcyc == int'(i_instr_len)) ? 0 : mcyc + 1;
    end else begin
      phase = phase + 1;
      o_strobe <= 1'b0;
      o_last_cycle <= 1'b0;
    end
  end
endmodule

/* File: bench/test_four_level_interrupt_controller.sv */
// Self-checking bench for the interrupt controller.
// Assumes the core model supplies strobe and instruction end.
module test_four_level_interrupt_controller
  import fic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_rst = 1'b1;
  logic i_sample_phase_strobe, i_instr_last_cycle;
  logic i_blocking_instr = 1'b0, i_return_from_irq_instr = 1'b0;
  logic i_ext0_request_pin_n = 1'b1, i_ext1_request_pin_n = 1'b1;
  logic i_ext0_trigger_type = 1'b1, i_ext1_trigger_type = 1'b0;
  logic i_timer0_overflow_set = 1'b0, i_timer1_overflow_set = 1'b0;
  logic i_timer2_overflow_flag = 1'b0, i_timer2_external_flag = 1'b0;
  logic i_serial_receive_flag = 1'b0, i_serial_transmit_flag = 1'b0;
  logic [3:0] i_flag_wr_en = 4'h0, i_flag_wr_data = 4'h0;
  logic       i_global_irq_enable = 1'b1;
  logic [5:0] i_source_enable = 6'h3F;
  logic [5:0] i_priority_low_bits = 6'h00, i_priority_high_bits = 6'h00;
  logic o_call_start, o_call_busy, o_pop_pc;
  logic o_ext0_request_flag, o_ext1_request_flag;
  logic o_timer0_overflow_flag, o_timer1_overflow_flag;
  logic [7:0] o_call_vector;
  logic [3:0] o_level_in_progress;
  logic [1:0] instr_len = 2'h1;
  int err_count = 0, n_compared = 0;

  always #5 i_sys_clk = ~i_sys_clk;
  fic_controller dut (.*);
  fic_core_model model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_instr_len(instr_len), .o_strobe(i_sample_phase_strobe),
    .o_last_cycle(i_instr_last_cycle));

  ////////////////////////////////////////
  task automatic complete_run();
    $display("err_count %0d n_compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Bounded wait for a call, then the vector
  task automatic wait_call(input logic [7:0] exp);
    int k;
    for (k = 0; k < 80; k++) begin
      if (o_call_start === 1'b1) break;
      tick(1);
    end
    if (k == 80) begin
      err_count++;
      $display("[ERR] %0t no call", $time);
      complete_run();
    end
    chk_byte(o_call_vector, exp, "vector");
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      tick(1);
      chk_bit(o_call_start, 1'b0, "unexpected call");
    end
  endtask
  task automatic do_ret(input logic [3:0] lvl);
    tick(12);
    i_return_from_irq_instr = 1'b1;
    tick(1);
    i_return_from_irq_instr = 1'b0;
    chk_bit(o_pop_pc, 1'b1, "pop");
    chk_byte({4'h0, o_level_in_progress}, {4'h0, lvl}, "level after ret");
    tick(1);
    chk_bit(o_pop_pc, 1'b0, "pop length");
  endtask
  task automatic pulse_t0();
    i_timer0_overflow_set = 1'b1;
    tick(1);
    i_timer0_overflow_set = 1'b0;
  endtask

  ////////////////////////////////////////
  task automatic s_timer0();
    i_blocking_instr = 1'b1;
    pulse_t0();
    chk_bit(o_timer0_overflow_flag, 1'b1, "t0 set");
    no_call(24);
    i_blocking_instr = 1'b0;
    wait_call(FIC_VEC_TMR0);
    chk_bit(o_timer0_overflow_flag, 1'b0, "t0 clear");
    chk_byte({4'h0, o_level_in_progress}, 8'h01, "lvl0");
    do_ret(4'h0);
  endtask
  task automatic s_ext();
    i_ext0_request_pin_n = 1'b0;
    tick(6);
    i_ext0_request_pin_n = 1'b1;
    wait_call(FIC_VEC_EXT0);
    chk_bit(o_ext0_request_flag, 1'b0, "edge clear");
    do_ret(4'h0);
    i_ext1_request_pin_n = 1'b0;
    wait_call(FIC_VEC_EXT1);
    chk_bit(o_ext1_request_flag, 1'b1, "level kept");
    i_ext1_request_pin_n = 1'b1;
    tick(12);
    chk_bit(o_ext1_request_flag, 1'b0, "follows pin");
    do_ret(4'h0);
  endtask
  task automatic s_poll();
    i_global_irq_enable = 1'b0;
    i_serial_receive_flag = 1'b1;
    i_serial_transmit_flag = 1'b1;
    i_timer2_overflow_flag = 1'b1;
    i_flag_wr_en = 4'h8;
    i_flag_wr_data = 4'h8;
    tick(1);
    i_flag_wr_en = 4'h0;
    no_call(24);
    i_global_irq_enable = 1'b1;
    wait_call(FIC_VEC_TMR1);
    do_ret(4'h0);
    wait_call(FIC_VEC_SERIAL);
    i_serial_receive_flag = 1'b0;
    i_serial_transmit_flag = 1'b0;
    do_ret(4'h0);
    wait_call(FIC_VEC_TMR2);
    i_timer2_overflow_flag = 1'b0;
    do_ret(4'h0);
  endtask
  task automatic s_preempt();
    i_priority_low_bits = 6'h0A;
    i_priority_high_bits = 6'h08;
    pulse_t0();
    wait_call(FIC_VEC_TMR0);
    chk_byte({4'h0, o_level_in_progress}, 8'h02, "lvl1");
    tick(12);
    pulse_t0();
    no_call(40);
    i_timer1_overflow_set = 1'b1;
    tick(1);
    i_timer1_overflow_set = 1'b0;
    wait_call(FIC_VEC_TMR1);
    chk_byte({4'h0, o_level_in_progress}, 8'h0A, "nest");
    chk_bit(o_timer1_overflow_flag, 1'b0, "t1 clear");
    do_ret(4'h2);
    do_ret(4'h0);
    wait_call(FIC_VEC_TMR0);
    do_ret(4'h0);
  endtask
  // Higher level raised in the first call cycle chains at the end of the second
  task automatic s_chain();
    pulse_t0();
    wait_call(FIC_VEC_TMR0);
    i_timer1_overflow_set = 1'b1;
    tick(1);
    i_timer1_overflow_set = 1'b0;
    no_call(6);
    tick(1);
    chk_bit(o_call_start, 1'b1, "chained call");
    chk_byte(o_call_vector, FIC_VEC_TMR1, "chain vector");
    chk_byte({4'h0, o_level_in_progress}, 8'h0A, "chain nest");
    do_ret(4'h2);
    do_ret(4'h0);
  endtask

  // Reset, then each scenario in turn
  initial begin
    tick(20);
    i_rst = 1'b0;
    tick(2);
    s_timer0();
    s_ext();
    s_poll();
    s_preempt();
    s_chain();
    complete_run();
  end
endmodule
